// [mpchu_defines.svh]
// register map, field positions, codes and reset values of the pwm unit
`ifndef MPCHU_DEFINES_SVH
`define MPCHU_DEFINES_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define MPCHU_CTRL    8'h00
`define MPCHU_TA_PER  8'h04
`define MPCHU_TB_PER  8'h08
`define MPCHU_TB_CMP  8'h0c
`define MPCHU_CH_VAL  8'h10
`define MPCHU_CH_SHD  8'h1c
`define MPCHU_MODE    8'h28
`define MPCHU_DT      8'h2c
`define MPCHU_HALL    8'h30
`define MPCHU_MOD     8'h34
`define MPCHU_STAT    8'h38
`define MPCHU_TA_CNT  8'h3c
`define MPCHU_TB_CNT  8'h40

// ----------------------------------------------------------------------
// control fields
// ----------------------------------------------------------------------
`define MPCHU_C_TA_RUN  0
`define MPCHU_C_TA_SS   1
`define MPCHU_C_TB_RUN  2
`define MPCHU_C_TB_SS   3
`define MPCHU_C_MC_EN   4
`define MPCHU_C_TB_SYN  6:5
`define MPCHU_C_TRANSFER_SOURCE_SELECT   9:7
`define MPCHU_C_TRANSFER_SYNC_SELECT   11:10
`define MPCHU_C_TRANSFER_ENABLE_FIELD    12
`define MPCHU_HALL_STR  15

// ----------------------------------------------------------------------
// channel mode codes
// ----------------------------------------------------------------------
`define MPCHU_M_CMP     4'h1
`define MPCHU_M_RISE    4'h2
`define MPCHU_M_FALL    4'h3
`define MPCHU_M_BOTH    4'h4
`define MPCHU_M_CMPCAP  4'h5
`define MPCHU_M_HALL    4'h8
`define MPCHU_M_HYST    4'h9

// ----------------------------------------------------------------------
// reset values and response codes
// ----------------------------------------------------------------------
`define MPCHU_PER_RST   16'hffff
`define MPCHU_DT_RST    8'h01
`define MPCHU_RESP_OK   2'b00
`define MPCHU_RESP_ERR  2'b10

`endif

// [mpchu_pkg.sv]
// types of the pwm capture and hall unit
package mpchu_pkg;

    // hall sequencer: running or idled after a wrong pattern
    typedef enum logic {
        HALL_RUN,
        HALL_IDLE
    } mpchu_hall_t;

    // complete state of the unit
    typedef struct packed {
        logic [15:0]       ta_cnt;
        logic [15:0]       tb_cnt;
        logic [15:0]       ta_per;
        logic [15:0]       tb_per;
        logic [15:0]       tb_cmp;
        logic [2:0][15:0]  val;
        logic [2:0][15:0]  shd;
        logic [2:0][3:0]   msel;
        logic [2:0][7:0]   dtc;
        logic [7:0]        dt;
        logic [12:0]       ctrl;
        logic [2:0]        current_hall_pattern;
        logic [2:0]        expected_hall_pattern;
        logic [5:0]        output_enable_pattern;
        logic [2:0]        hs_current_hall_pattern;
        logic [2:0]        hs_expected_hall_pattern;
        logic [5:0]        hs_pat;
        logic [17:0]       modsel;
        logic [6:0]        stat;
        logic              pend;
        mpchu_hall_t       hall;
        logic [2:0]        pin_m;
        logic [2:0]        pin_s;
        logic [2:0]        pin_p;
        logic [2:0]        pos_m;
        logic [2:0]        pos_s;
        logic [2:0]        pos_p;
        logic              trap_m;
        logic              trap_s;
        logic [2:0]        cmp_p;
        logic [5:0]        pwm;
        logic              tbo;
        logic              aw_ok;
        logic              w_ok;
        logic [7:0]        awa;
        logic [31:0]       wd;
        logic [3:0]        ws;
        logic              bv;
        logic [1:0]        br;
        logic              rv;
        logic [1:0]        rr;
        logic [31:0]       rd;
    } mpchu_state_t;

endpackage : mpchu_pkg

// [mpchu_unit.sv]
// two-timer pwm, capture and hall commutation unit with axi4-lite registers
`timescale 1ns/1ps
`default_nettype none
`include "mpchu_defines.svh"

// Functional notes
// - timer_a channels capture/compare; timer_b compare only
// - each channel owns an independent dead-time counter
// - selected pin edge captures count, sets flag
// - single-shot timer_a halts at period end
// - mode 1001 forces compare low on low position: high side off, low side on
// - timer_b starts on selected timer_a event
// - multichannel enable gates outputs by pattern
// - shadow pattern copies on selected timer event, or at once with no sync selected
// - per-line enables combine all modulation sources
// - trap state disables enabled output lines
// - hall shadow write with request asks transfer
// - mode 1000 filter samples hall at one
// - sample equal current pattern is ignored
// - expected pattern flags event, resets timer_a
// - hall transfer updates current and expected together
// - wrong pattern flags, idles, clears output pattern
// - brushless mode captures ch0, ch1/2 compare only
// - ch1 match triggers pattern transfer if enabled
// - ch2 match in brushless mode flags timeout
module mpchu_unit
    import mpchu_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [2:0]  channel_pin,
    input  wire logic [2:0]  position_input,
    input  wire logic        emergency_stop_input,
    output logic [5:0]       pwm_out,
    output logic             timer_b_out
);

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------

    // channel mode runs the compare path
    function automatic logic is_cmp(input logic [3:0] m);
        return m == `MPCHU_M_CMP || m == `MPCHU_M_CMPCAP ||
               m == `MPCHU_M_HYST;
    endfunction : is_cmp

    // channel mode accepts this pin edge as capture event
    function automatic logic cap_hit(input logic [3:0] m,
                                     input logic r, input logic f);
        case (m)
            `MPCHU_M_RISE:   return r;
            `MPCHU_M_FALL:   return f;
            `MPCHU_M_BOTH,
            `MPCHU_M_CMPCAP: return r | f;
            default:         return 1'b0;
        endcase
    endfunction : cap_hit

    // byte-lane merge of a bus write
    function automatic logic [31:0] wmerge(input logic [31:0] o,
                                           input logic [31:0] d,
                                           input logic [3:0] b);
        logic [31:0] r;
        r = o;
        for (int k = 0; k < 4; k++) begin
            if (b[k]) begin
                r[8*k +: 8] = d[8*k +: 8];
            end
        end
        return r;
    endfunction : wmerge

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    mpchu_state_t s;        // registered state
    mpchu_state_t next_s;   // next state
    logic [2:0]   rise;     // synced capture pin rising edges
    logic [2:0]   fall;     // synced capture pin falling edges
    logic [2:0]   cmpm;     // channel compare match events
    logic         ta_pm;    // timer_a period match
    logic         tb_pm;    // timer_b period match
    logic         hmode;    // brushless hall mode on channel 0
    logic         hsmp;     // hall filter sample point
    logic         correct_hall_event;      // correct hall event
    logic         wrong_hall_event;      // wrong hall event
    logic         src;      // selected transfer source fired
    logic         syn;      // selected transfer sync fired
    logic [31:0]  wv;       // merged write value
    logic [31:0]  rdv;      // read mux value
    logic         rhit;     // read address mapped
    logic         whit;     // write address mapped
    logic [2:0]   cmp;      // raw compare states
    logic [5:0]   tas;      // timer_a line signals after dead time
    logic         any;      // line has a timer source enabled
    logic         mv;       // line modulated value

    // ------------------------------------------------------------------
    // event decode from registered state
    // ------------------------------------------------------------------
    assign rise  = s.pin_s & ~s.pin_p;
    assign fall  = ~s.pin_s & s.pin_p;
    assign ta_pm = s.ctrl[`MPCHU_C_TA_RUN] && s.ta_cnt == s.ta_per;
    assign tb_pm = s.ctrl[`MPCHU_C_TB_RUN] && s.tb_cnt == s.tb_per;
    assign hmode = s.msel[0] == `MPCHU_M_HALL;
    assign hsmp  = hmode && s.dtc[0] == 8'h01;
    assign correct_hall_event   = hsmp && s.hall == HALL_RUN &&
                   s.pos_s != s.current_hall_pattern && s.pos_s == s.expected_hall_pattern;
    assign wrong_hall_event   = hsmp && s.hall == HALL_RUN &&
                   s.pos_s != s.current_hall_pattern && s.pos_s != s.expected_hall_pattern;
    assign wv    = wmerge(32'h0, s.wd, s.ws);

    // ------------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        next_s = s;
        cmpm   = '0;
        cmp    = '0;
        tas    = '0;
        rdv    = 32'h0;
        rhit   = 1'b1;
        whit   = 1'b1;
        src    = 1'b0;
        syn    = 1'b0;
        any    = 1'b0;
        mv     = 1'b0;

        // two-flop input synchronisers
        next_s.pin_m  = channel_pin;
        next_s.pin_s  = s.pin_m;
        next_s.pin_p  = s.pin_s;
        next_s.pos_m  = position_input;
        next_s.pos_s  = s.pos_m;
        next_s.pos_p  = s.pos_s;
        next_s.trap_m = emergency_stop_input;
        next_s.trap_s = s.trap_m;

        // bus: latch address and data in either order
        if (s_axi_awvalid && s_axi_awready) begin
            next_s.aw_ok = 1'b1;
            next_s.awa   = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_s.w_ok = 1'b1;
            next_s.wd   = s_axi_wdata;
            next_s.ws   = s_axi_wstrb;
        end
        if (s.bv && s_axi_bready) begin
            next_s.bv = 1'b0;
        end

        // bus: perform write once both halves are held
        if (s.aw_ok && s.w_ok && !s.bv) begin
            next_s.aw_ok = 1'b0;
            next_s.w_ok  = 1'b0;
            next_s.bv    = 1'b1;
            case (s.awa)
                `MPCHU_CTRL:   next_s.ctrl = 13'(wmerge(32'(s.ctrl),
                                   s.wd, s.ws));
                `MPCHU_TA_PER: next_s.ta_per = 16'(wmerge(32'(s.ta_per),
                                   s.wd, s.ws));
                `MPCHU_TB_PER: next_s.tb_per = 16'(wmerge(32'(s.tb_per),
                                   s.wd, s.ws));
                `MPCHU_TB_CMP: next_s.tb_cmp = 16'(wmerge(32'(s.tb_cmp),
                                   s.wd, s.ws));
                `MPCHU_MODE:   next_s.msel = 12'(wmerge(32'(s.msel),
                                   s.wd, s.ws));
                `MPCHU_DT:     next_s.dt = 8'(wmerge(32'(s.dt),
                                   s.wd, s.ws));
                `MPCHU_MOD:    next_s.modsel = 18'(wmerge(32'(s.modsel),
                                   s.wd, s.ws));
                `MPCHU_STAT:   next_s.stat = s.stat & ~wv[6:0];
                `MPCHU_HALL: begin
                    // pattern shadow, current and expected shadow
                    if (s.ws[0]) next_s.hs_pat  = s.wd[5:0];
                    if (s.ws[1]) begin
                        next_s.hs_current_hall_pattern = s.wd[10:8];
                        next_s.hs_expected_hall_pattern = s.wd[14:12];
                        if (s.wd[`MPCHU_HALL_STR]) begin
                            next_s.pend = 1'b1;
                        end
                    end
                end
                default: begin
                    whit = 1'b0;
                    // compare values are written into the shadow
                    for (int i = 0; i < 3; i++) begin
                        if (s.awa == `MPCHU_CH_VAL + 8'(4*i) ||
                            s.awa == `MPCHU_CH_SHD + 8'(4*i)) begin
                            next_s.shd[i] = 16'(wmerge(32'(s.shd[i]),
                                s.wd, s.ws));
                            whit = 1'b1;
                        end
                    end
                end
            endcase
            next_s.br = whit ? `MPCHU_RESP_OK : `MPCHU_RESP_ERR;
        end

        // bus: read, one cycle after the address is taken
        if (s.rv && s_axi_rready) begin
            next_s.rv = 1'b0;
        end
        case (s_axi_araddr)
            `MPCHU_CTRL:   rdv = 32'(s.ctrl);
            `MPCHU_TA_PER: rdv = 32'(s.ta_per);
            `MPCHU_TB_PER: rdv = 32'(s.tb_per);
            `MPCHU_TB_CMP: rdv = 32'(s.tb_cmp);
            `MPCHU_MODE:   rdv = 32'(s.msel);
            `MPCHU_DT:     rdv = 32'(s.dt);
            `MPCHU_MOD:    rdv = 32'(s.modsel);
            `MPCHU_STAT:   rdv = {24'h0, s.hall == HALL_IDLE, s.stat};
            `MPCHU_TA_CNT: rdv = 32'(s.ta_cnt);
            `MPCHU_TB_CNT: rdv = 32'(s.tb_cnt);
            `MPCHU_HALL:   rdv = {1'b0, s.expected_hall_pattern, 1'b0, s.current_hall_pattern,
                                  2'b0, s.output_enable_pattern, 1'b0, s.hs_expected_hall_pattern,
                                  1'b0, s.hs_current_hall_pattern, 2'b0, s.hs_pat};
            default: begin
                rhit = 1'b0;
                for (int i = 0; i < 3; i++) begin
                    if (s_axi_araddr == `MPCHU_CH_VAL + 8'(4*i)) begin
                        rdv  = 32'(s.val[i]);
                        rhit = 1'b1;
                    end
                    if (s_axi_araddr == `MPCHU_CH_SHD + 8'(4*i)) begin
                        rdv  = 32'(s.shd[i]);
                        rhit = 1'b1;
                    end
                end
            end
        endcase
        if (s_axi_arvalid && s_axi_arready) begin
            next_s.rv = 1'b1;
            next_s.rd = rdv;
            next_s.rr = rhit ? `MPCHU_RESP_OK : `MPCHU_RESP_ERR;
        end

        // timer_a: edge-aligned up count, shadow load at period
        if (s.ctrl[`MPCHU_C_TA_RUN]) begin
            if (ta_pm) begin
                next_s.ta_cnt = 16'h0;
                next_s.val    = s.shd;
                if (s.ctrl[`MPCHU_C_TA_SS]) begin
                    next_s.ctrl[`MPCHU_C_TA_RUN] = 1'b0;
                end
            end else begin
                next_s.ta_cnt = s.ta_cnt + 16'h1;
            end
        end

        // channels: compare state, match, capture, dead time
        for (int i = 0; i < 3; i++) begin
            cmp[i]  = is_cmp(s.msel[i]) && s.ta_cnt < s.val[i];
            cmpm[i] = s.ctrl[`MPCHU_C_TA_RUN] && s.ta_cnt == s.val[i];
            if (s.msel[i] == `MPCHU_M_HYST && !s.pos_s[i]) begin
                cmp[i] = 1'b0;
            end
            if (cap_hit(s.msel[i], rise[i], fall[i])) begin
                next_s.val[i]  = s.ta_cnt;
                next_s.shd[i]  = s.ta_cnt;
                next_s.stat[i] = 1'b1;
            end
            next_s.cmp_p[i] = cmp[i];
            if (i == 0 && hmode) begin
                // channel 0 counter acts as the hall noise filter
                if (s.pos_s != s.pos_p) begin
                    next_s.dtc[0] = (s.dt == 8'h0) ? 8'h1 : s.dt;
                end else if (s.dtc[0] != 8'h0) begin
                    next_s.dtc[0] = s.dtc[0] - 8'h1;
                end
            end else if (cmp[i] != s.cmp_p[i]) begin
                next_s.dtc[i] = s.dt;
            end else if (s.dtc[i] != 8'h0) begin
                next_s.dtc[i] = s.dtc[i] - 8'h1;
            end
            // high side on compare, low side on its complement
            tas[2*i]   = cmp[i] && s.dtc[i] == 8'h0;
            tas[2*i+1] = !cmp[i] && is_cmp(s.msel[i]) &&
                         s.dtc[i] == 8'h0;
        end
        if (hmode) begin
            tas = '0;
            if (cmpm[2]) begin
                next_s.stat[5] = 1'b1;
            end
        end

        // hall: correct event captures speed and restarts timer_a
        if (correct_hall_event) begin
            next_s.stat[3] = 1'b1;
            next_s.ta_cnt  = 16'h0;
            next_s.val[0]  = s.ta_cnt;
            next_s.shd[0]  = s.ta_cnt;
        end

        // timer_b: start on selected timer_a event, compare only
        if (!s.ctrl[`MPCHU_C_TB_RUN] &&
            ((s.ctrl[`MPCHU_C_TB_SYN] == 2'd1 && ta_pm) ||
             (s.ctrl[`MPCHU_C_TB_SYN] == 2'd2 && cmpm[0]))) begin
            next_s.ctrl[`MPCHU_C_TB_RUN] = 1'b1;
            next_s.tb_cnt = 16'h0;
        end else if (s.ctrl[`MPCHU_C_TB_RUN]) begin
            if (tb_pm) begin
                next_s.tb_cnt = 16'h0;
                if (s.ctrl[`MPCHU_C_TB_SS]) begin
                    next_s.ctrl[`MPCHU_C_TB_RUN] = 1'b0;
                end
            end else begin
                next_s.tb_cnt = s.tb_cnt + 16'h1;
            end
        end
        next_s.tbo = s.ctrl[`MPCHU_C_TB_RUN] && s.tb_cnt < s.tb_cmp;

        // pattern transfer: source arms, sync event copies
        case (s.ctrl[`MPCHU_C_TRANSFER_SOURCE_SELECT])
            3'd1:    src = ta_pm;
            3'd2:    src = tb_pm;
            3'd3:    src = correct_hall_event;
            3'd4:    src = hmode && cmpm[1] &&
                           s.ctrl[`MPCHU_C_TRANSFER_ENABLE_FIELD];
            default: src = 1'b0;
        endcase
        case (s.ctrl[`MPCHU_C_TRANSFER_SYNC_SELECT])
            2'd1:    syn = ta_pm;
            2'd2:    syn = tb_pm;
            default: syn = 1'b1;
        endcase
        if (src && s.hall == HALL_RUN) begin
            next_s.pend = 1'b1;
        end
        if (s.pend && syn) begin
            next_s.pend = 1'b0;
            next_s.output_enable_pattern = s.hs_pat;
            next_s.current_hall_pattern = s.hs_current_hall_pattern;
            next_s.expected_hall_pattern = s.hs_expected_hall_pattern;
            next_s.hall = HALL_RUN;
        end
        if (wrong_hall_event) begin
            next_s.stat[4] = 1'b1;
            next_s.hall    = HALL_IDLE;
            next_s.output_enable_pattern    = 6'h0;
            next_s.pend    = 1'b0;
        end

        // trap flag, sticky until cleared while input stays inactive
        if (s.trap_s) begin
            next_s.stat[6] = 1'b1;
        end

        // output combining per line
        for (int i = 0; i < 6; i++) begin
            any = s.modsel[i] | s.modsel[6+i];
            mv  = (s.modsel[i] & tas[i]) |
                  (s.modsel[6+i] & s.tbo);
            if (s.ctrl[`MPCHU_C_MC_EN]) begin
                mv = (any ? mv : 1'b1) & s.output_enable_pattern[i];
            end
            if (s.modsel[12+i] && s.trap_s) begin
                mv = 1'b0;
            end
            next_s.pwm[i] = mv;
        end
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s        <= '0;
            s.ta_per <= `MPCHU_PER_RST;
            s.tb_per <= `MPCHU_PER_RST;
            s.dt     <= `MPCHU_DT_RST;
            s.hall   <= HALL_RUN;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign s_axi_awready = !s.aw_ok && !s.bv;
    assign s_axi_wready  = !s.w_ok && !s.bv;
    assign s_axi_bvalid  = s.bv;
    assign s_axi_bresp   = s.br;
    assign s_axi_arready = !s.rv;
    assign s_axi_rvalid  = s.rv;
    assign s_axi_rdata   = s.rd;
    assign s_axi_rresp   = s.rr;
    assign pwm_out       = s.pwm;
    assign timer_b_out   = s.tbo;

endmodule : mpchu_unit
`default_nettype wire

// [mpchu_unit_properties.sv]
// bus handshake checker of the pwm unit
`timescale 1ns/1ps
`default_nettype none
module mpchu_unit_properties (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    AST_AW_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("awready high with response pending");
    AST_W_BLOCK: assert property (s_axi_bvalid |-> !s_axi_wready)
        else $error("wready high with response pending");
    AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("arready high with read data pending");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    AST_B_LAT: assert property (s_axi_awvalid && s_axi_awready
        && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("write answer late");
    AST_B_DROP: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    AST_R_DROP: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data repeated");
    // main scenarios seen
    cover property (s_axi_bvalid && s_axi_bready);
    cover property (s_axi_rvalid && s_axi_rready);
    cover property (s_axi_arvalid && s_axi_awvalid);
endmodule : mpchu_unit_properties
bind mpchu_unit mpchu_unit_properties u_chk (.aclk, .aresetn, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata);
`default_nettype wire

// [mpchu_hall_model.sv]
// hall sensor model, one rotor step per request
`timescale 1ns/1ps
`default_nettype none
module mpchu_hall_model (
    input  wire logic       aclk,
    input  wire logic       step,
    input  wire logic       fault,
    output logic      [2:0] position_input
);
    logic [2:0] seq [6] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
    int         idx = 0;
    // advance the block commutation sequence
    always @(posedge aclk) begin
        if (step) begin
            idx <= (idx + 1) % 6;
        end
    end
    // a broken sensor shows the illegal code
    assign position_input = fault ? 3'h7 : seq[idx];
endmodule : mpchu_hall_model
`default_nettype wire

// [tb_motor_pwm_capture_hall_unit.sv]
// register level test of the pwm capture and hall unit
`timescale 1ns/1ps
`default_nettype none
`include "mpchu_defines.svh"
module tb_motor_pwm_capture_hall_unit;
    import mpchu_pkg::*;
    logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
    logic [7:0] awa = 0, ara = 0;
    logic [31:0] wd = 0, rdt, rv, rw;
    logic awr, wr_, bv, arr, rvl, tbo, trap = 0, step = 0, flt = 0;
    logic [1:0] br, rr, rs;
    logic [2:0] cpin = 0, pos;
    logic [5:0] pwm;
    int err_count = 0, num_checks = 0;
    always #4 aclk = ~aclk;
    mpchu_unit dut (.aclk, .aresetn, .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wv), .s_axi_wready(wr_), .s_axi_bresp(br),
        .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdt),
        .s_axi_rresp(rr), .s_axi_rvalid(rvl), .s_axi_rready(rry),
        .channel_pin(cpin), .position_input(pos),
        .emergency_stop_input(trap), .pwm_out(pwm), .timer_b_out(tbo));
    mpchu_hall_model u_hall (.aclk, .step, .fault(flt), .position_input(pos));
    task automatic finish_test;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : finish_test
    task automatic chk(input string nm, input logic [31:0] s, e);
        num_checks++;
        if (s !== e) begin
            err_count++;
            $display("wrong value %s exp %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic tmo(input int n);
        if (n >= 100) begin
            err_count++;
            finish_test();
        end
    endtask : tmo
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bry <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (awr) awv <= 1'b0;
            if (wr_) wv <= 1'b0;
        end while (!bv && n < 100);
        rs = br;
        bry <= 1'b0;
        @(posedge aclk);
        tmo(n);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        int n = 0;
        ara <= a;
        arv <= 1'b1;
        rry <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (arr) arv <= 1'b0;
        end while (!rvl && n < 100);
        rv = rdt;
        rs = rr;
        rry <= 1'b0;
        @(posedge aclk);
        tmo(n);
    endtask : rd
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(`MPCHU_TA_PER);
        chk("ta_per", rv, 32'hffff);
        rd(`MPCHU_DT);
        chk("dt", rv, 32'h1);
        rd(8'h44);
        chk("unmapped", {rs, rv[29:0]}, 32'h80000000);
        wr(8'h44, 32'h0);
        chk("unmapped wr", 32'(rs), 32'h2);
        wr(`MPCHU_TA_PER, 32'h8);
        wr(`MPCHU_MODE, 32'h2);
        wr(`MPCHU_CTRL, 32'h11);
        cpin <= 3'h1;
        repeat (8) @(posedge aclk);
        rd(`MPCHU_STAT);
        chk("capture", rv & 32'h7, 32'h1);
        wr(`MPCHU_CTRL, 32'h13);
        repeat (40) @(posedge aclk);
        rd(`MPCHU_TA_CNT);
        rw = rv;
        repeat (10) @(posedge aclk);
        rd(`MPCHU_TA_CNT);
        chk("single shot", rv, rw);
        wr(`MPCHU_MOD, 32'h3f000);
        wr(`MPCHU_HALL, 32'hb115);
        repeat (6) @(posedge aclk);
        chk("pattern", 32'(pwm), 32'h15);
        rd(`MPCHU_HALL);
        chk("hall load", rv & 32'h773f0000, 32'h31150000);
        trap <= 1'b1;
        repeat (6) @(posedge aclk);
        chk("trap", 32'(pwm), 32'h0);
        trap <= 1'b0;
        wr(`MPCHU_MODE, 32'h8);
        wr(`MPCHU_DT, 32'h4);
        step <= 1'b1;
        @(posedge aclk);
        step <= 1'b0;
        repeat (30) @(posedge aclk);
        rd(`MPCHU_STAT);
        chk("correct", rv & 32'h18, 32'h8);
        flt <= 1'b1;
        repeat (30) @(posedge aclk);
        rd(`MPCHU_STAT);
        chk("wrong", rv & 32'h90, 32'h90);
        chk("idle out", 32'(pwm), 32'h0);
        flt <= 1'b0;
        wr(`MPCHU_HALL, 32'hb115);
        repeat (12) @(posedge aclk);
        chk("restart", 32'(pwm), 32'h15);
        wr(`MPCHU_TB_CMP, 32'h40);
        wr(`MPCHU_CTRL, 32'h14);
        repeat (4) @(posedge aclk);
        chk("timer_b on", 32'(tbo), 32'h1);
        repeat (80) @(posedge aclk);
        chk("timer_b off", 32'(tbo), 32'h0);
        finish_test();
    end
endmodule : tb_motor_pwm_capture_hall_unit
`default_nettype wire
